// ===== logic/mv_autotune.sv
// autotune sequencer: limit cycle on measured value around setpoint
// assumes measured value and setpoint in the same tenths units
`timescale 1ns/10ps
`include "mv_defines.svh"
module mv_autotune
  import mv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic reduced,
  input wire logic cancel,
  input wire mv_pkg::at_cfg_s cfg,
  input wire logic signed [15:0] measured_value,
  input wire logic signed [15:0] setpoint_value,
  output logic busy,
  output logic signed [15:0] drive,
  output logic done,
  output logic signed [15:0] pid_gain,
  output logic signed [15:0] tuned_sp
);
  typedef enum logic [1:0] {idle, temp_pass, cycling} at_e;
  at_e st_ff, nxt_st;
  logic high_ff, nxt_high;
  logic [2:0] cnt_ff, nxt_cnt;
  logic signed [15:0] sp_ff;
  wire signed [15:0] control_deviation = setpoint_value - measured_value;
  wire signed [15:0] abs_dev = control_deviation[15] ? -control_deviation : control_deviation;
  wire signed [15:0] swing = reduced ? cfg.amp : `FULL_MV;
  wire big_dev = reduced && (abs_dev > cfg.judge);
  wire go_low = high_ff && (measured_value > sp_ff + cfg.hys);
  wire go_high = !high_ff && (measured_value < sp_ff - cfg.hys);
  wire last = (go_low || go_high) && (cnt_ff == `CYCLES_DONE - 3'h1);
  always_comb begin
    nxt_st = st_ff;
    nxt_high = high_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      idle: begin
        if (start) begin
          nxt_st = big_dev ? temp_pass : cycling;
          nxt_high = 1'b1;
          nxt_cnt = 3'h0;
        end
      end
      temp_pass: begin
        if (!big_dev) nxt_st = cycling;
      end
      default: begin
        if (go_low || go_high) begin
          nxt_high = go_high;
          nxt_cnt = cnt_ff + 3'h1;
        end
        if (last) nxt_st = idle;
      end
    endcase
    if (cancel) nxt_st = idle;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= idle;
      high_ff <= 1'b0;
      cnt_ff <= 3'h0;
      sp_ff <= `ZERO_MV;
      done <= 1'b0;
      pid_gain <= `GAIN_RST;
      tuned_sp <= `ZERO_MV;
    end else begin
      st_ff <= nxt_st;
      high_ff <= nxt_high;
      cnt_ff <= nxt_cnt;
      if (st_ff == idle && start) sp_ff <= setpoint_value;
      done <= (st_ff == cycling) && last && !cancel;
      if ((st_ff == cycling) && last && !cancel) begin
        pid_gain <= cfg.gain;
        tuned_sp <= sp_ff;
      end
    end
  end
  assign busy = st_ff != idle;
  assign drive = (st_ff == idle) ? `ZERO_MV : (nxt_high ? swing : `ZERO_MV);
  a_done_after_cycle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    done |-> $past(st_ff) == cycling)
    else $error("tune done without limit cycle");
  a_cancel_idles: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cancel |=> st_ff == idle)
    else $error("cancel did not stop tuning");
endmodule

// ===== logic/mv_clamp.sv
// signed clamp of a value into a range
// assumes lo <= hi is settled by the caller
`timescale 1ns/10ps
module mv_clamp #(
  parameter int W = 16
) (
  input wire logic signed [W-1:0] val,
  input wire logic signed [W-1:0] lo,
  input wire logic signed [W-1:0] hi,
  output logic signed [W-1:0] res
);
  wire below = val < lo;
  wire above = val > hi;
  assign res = above ? hi : (below ? lo : val);
endmodule

// ===== logic/mv_defines.svh
// constants for output select, limiter and autotune logic
// values except the 3-bit CYCLES_DONE count are tenths of a percent or tenths of engineering units, signed 16 bit
// Notes on behaviour
// - manual mode drives stored manual output
// - fixed outputs clamp to mode-dependent range
// - event input off auto, on manual
// - stopped channel drives stored stop output
// - heat/cool sign picks cooling or heating side
// - default stop output gives no output
// - priority manual, then stop, then input error
// - input error drives stored error output except during autotune
// - limiter clamps calculated output only
// - heat/cool limits upper 0..105, lower -105..0
// - lower above upper acts as upper
// - limiter only in two-dof pid without self-tuning
// - autotune forces limit cycle, then stores constants
// - no autotune start when stopped, manual, on/off
// - during autotune only run, mode, tune, latch commands
// - stop cancels autotune; run does not resume
// - reduced tuning refused in heat/cool mode
// - limit cycle hysteresis 0.1..999.9, default 0.8
// - reduced swing amplitude 5..50, default 20, full ignores
// - temporary pass when deviation exceeds threshold 150.0
// - full tuning ignores amplitude and threshold
// - computed constants scaled by gain 0.1..10.0
`ifndef MV_DEFINES_SVH
`define MV_DEFINES_SVH
`define STD_MIN 16'shffce
`define STD_MAX 16'sh041a
`define HC_MIN 16'shfbe6
`define HC_MAX 16'sh041a
`define ZERO_MV 16'sh0000
`define LIM_HI_RST 16'sh041a
`define LIM_LO_RST 16'shfbe6
`define HYS_MIN 16'sh0001
`define HYS_MAX 16'sh270f
`define HYS_RST 16'sh0008
`define AMP_MIN 16'sh0032
`define AMP_MAX 16'sh01f4
`define AMP_RST 16'sh00c8
`define JDG_MIN 16'sh0000
`define JDG_MAX 16'sh270f
`define JDG_RST 16'sh05dc
`define GAIN_MIN 16'sh0001
`define GAIN_MAX 16'sh0064
`define GAIN_RST 16'sh0008
`define FULL_MV 16'sh03e8
`define CYCLES_DONE 3'h4
`endif

// ===== logic/mv_pkg.sv
// types for output select and autotune logic
// assumes mv_defines.svh is included by the design files
package mv_pkg;
  typedef enum logic [3:0] {
    cmd_none, cmd_run, cmd_stop, cmd_auto, cmd_manual, cmd_at_full, cmd_at_reduced,
    cmd_at_cancel, cmd_latch_cancel, cmd_param
  } cmd_e;
  typedef enum logic [2:0] {
    par_manual, par_stop, par_err, par_lim_hi, par_lim_lo, par_hys, par_amp, par_gain
  } par_e;
  typedef struct packed {
    cmd_e cmd;
    par_e par;
    logic signed [15:0] value;
  } host_cmd_s;
  typedef struct packed {
    logic signed [15:0] heat;
    logic signed [15:0] cool;
  } out_pair_s;
  typedef struct packed {
    logic signed [15:0] hys;
    logic signed [15:0] amp;
    logic signed [15:0] judge;
    logic signed [15:0] gain;
  } at_cfg_s;
endpackage

// ===== logic/mv_select.sv
// per-channel output selection, limiter and autotune control
// assumes host commands are one-cycle strobes; pid output is supplied as input
`timescale 1ns/10ps
`include "mv_defines.svh"
module mv_select
  import mv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire mv_pkg::host_cmd_s host_cmd,
  input wire logic event_mode_en,
  input wire logic event_in,
  input wire logic heat_cool,
  input wire logic two_dof_pid,
  input wire logic self_tuning_en,
  input wire logic on_off_ctl,
  input wire logic pv_error,
  input wire logic rsp_error,
  input wire logic signed [15:0] pid_output,
  input wire logic signed [15:0] measured_value,
  input wire logic signed [15:0] setpoint_value,
  output mv_pkg::out_pair_s controller_output,
  output logic signed [15:0] output_total,
  output logic running,
  output logic manual_mode,
  output logic auto_tuning,
  output logic cmd_rejected,
  output logic tune_done,
  output logic signed [15:0] tuned_gain,
  output logic signed [15:0] tuned_sp
);
  logic run_ff, man_cmd_ff;
  logic signed [15:0] man_ff, stop_ff, err_ff, hi_ff, lo_ff;
  at_cfg_s cfg_ff;
  logic at_red_ff;
  wire at_busy;
  wire at_done;
  wire signed [15:0] at_drive;
  wire signed [15:0] at_gain;
  wire signed [15:0] at_sp;
  wire signed [15:0] range_lo = heat_cool ? `HC_MIN : `STD_MIN;
  wire signed [15:0] range_hi = heat_cool ? `HC_MAX : `STD_MAX;
  wire manual_now = event_mode_en ? event_in : man_cmd_ff;
  wire is_cmd = host_cmd.cmd != cmd_none;
  wire tune_ok_cmd = (host_cmd.cmd == cmd_run) || (host_cmd.cmd == cmd_stop) ||
    (host_cmd.cmd == cmd_auto) || (host_cmd.cmd == cmd_manual) ||
    (host_cmd.cmd == cmd_at_full) || (host_cmd.cmd == cmd_at_reduced) ||
    (host_cmd.cmd == cmd_at_cancel) || (host_cmd.cmd == cmd_latch_cancel);
  wire blocked = at_busy && is_cmd && !tune_ok_cmd;
  wire at_req = (host_cmd.cmd == cmd_at_full) || (host_cmd.cmd == cmd_at_reduced);
  wire at_refuse = !run_ff || manual_now || on_off_ctl ||
    (heat_cool && host_cmd.cmd == cmd_at_reduced);
  wire at_start = at_req && !at_refuse && !at_busy;
  wire at_red_now = at_busy ? at_red_ff : (host_cmd.cmd == cmd_at_reduced);
  wire at_cancel = at_busy && ((host_cmd.cmd == cmd_stop) ||
    (host_cmd.cmd == cmd_at_cancel) || manual_now || !run_ff);
  wire bad = (at_req && at_refuse) || blocked;
  wire pwr = (host_cmd.cmd == cmd_param) && !blocked;
  wire signed [15:0] pv;
  wire signed [15:0] fix_val;
  wire signed [15:0] lim_in_lo;
  wire signed [15:0] lim_hi_eff;
  wire signed [15:0] lim_hi_raw;
  wire signed [15:0] lim_lo_raw;
  wire signed [15:0] limited;
  wire signed [15:0] wr_hi;
  wire signed [15:0] wr_lo;
  wire signed [15:0] wr_std;
  wire signed [15:0] hys_v;
  wire signed [15:0] amp_v;
  wire signed [15:0] gain_v;
  assign wr_hi = heat_cool ? `ZERO_MV : `STD_MIN;
  assign wr_lo = heat_cool ? `ZERO_MV : `STD_MAX;
  mv_clamp u_wr_std (.val(host_cmd.value), .lo(range_lo), .hi(range_hi), .res(wr_std));
  mv_clamp u_wr_hi (.val(host_cmd.value), .lo(wr_hi), .hi(range_hi), .res(lim_hi_raw));
  mv_clamp u_wr_lo (.val(host_cmd.value), .lo(range_lo), .hi(wr_lo), .res(lim_lo_raw));
  mv_clamp u_hys (.val(host_cmd.value), .lo(`HYS_MIN), .hi(`HYS_MAX), .res(hys_v));
  mv_clamp u_amp (.val(host_cmd.value), .lo(`AMP_MIN), .hi(`AMP_MAX), .res(amp_v));
  mv_clamp u_gain (.val(host_cmd.value), .lo(`GAIN_MIN), .hi(`GAIN_MAX), .res(gain_v));
  assign lim_hi_eff = (lo_ff > hi_ff) ? lo_ff : hi_ff;
  assign lim_in_lo = (lo_ff > hi_ff) ? hi_ff : lo_ff;
  mv_clamp u_lim (.val(pid_output), .lo(lim_in_lo), .hi(lim_hi_eff), .res(limited));
  wire lim_on = two_dof_pid && !self_tuning_en;
  wire signed [15:0] auto_val = lim_on ? limited : pid_output;
  assign fix_val = manual_now ? man_ff :
    (!run_ff ? stop_ff :
    ((pv_error || rsp_error) ? err_ff : auto_val));
  assign pv = (!manual_now && run_ff && at_busy) ? at_drive : fix_val;
  wire signed [15:0] heat_v = (heat_cool && pv[15]) ? `ZERO_MV : pv;
  wire signed [15:0] cool_v = (heat_cool && pv[15]) ? -pv : `ZERO_MV;
  mv_autotune u_at (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(at_start),
    .reduced(at_red_now),
    .cancel(at_cancel),
    .cfg(cfg_ff),
    .measured_value(measured_value),
    .setpoint_value(setpoint_value),
    .busy(at_busy),
    .drive(at_drive),
    .done(at_done),
    .pid_gain(at_gain),
    .tuned_sp(at_sp)
  );
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_ff <= 1'b0;
      man_cmd_ff <= 1'b0;
      man_ff <= `ZERO_MV;
      stop_ff <= `ZERO_MV;
      err_ff <= `ZERO_MV;
      hi_ff <= `LIM_HI_RST;
      lo_ff <= `LIM_LO_RST;
      cfg_ff <= {`HYS_RST, `AMP_RST, `JDG_RST, `GAIN_RST};
      at_red_ff <= 1'b0;
    end else begin
      if (host_cmd.cmd == cmd_run) run_ff <= 1'b1;
      if (host_cmd.cmd == cmd_stop) run_ff <= 1'b0;
      if (host_cmd.cmd == cmd_auto) man_cmd_ff <= 1'b0;
      if (host_cmd.cmd == cmd_manual) man_cmd_ff <= 1'b1;
      if (at_start) at_red_ff <= host_cmd.cmd == cmd_at_reduced;
      if (pwr && host_cmd.par == par_manual) man_ff <= wr_std;
      if (pwr && host_cmd.par == par_stop) stop_ff <= wr_std;
      if (pwr && host_cmd.par == par_err) err_ff <= wr_std;
      if (pwr && host_cmd.par == par_lim_hi) hi_ff <= lim_hi_raw;
      if (pwr && host_cmd.par == par_lim_lo) lo_ff <= lim_lo_raw;
      if (pwr && host_cmd.par == par_hys) cfg_ff.hys <= hys_v;
      if (pwr && host_cmd.par == par_amp) cfg_ff.amp <= amp_v;
      if (pwr && host_cmd.par == par_gain) cfg_ff.gain <= gain_v;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      controller_output <= '0;
      output_total <= `ZERO_MV;
      running <= 1'b0;
      manual_mode <= 1'b0;
      auto_tuning <= 1'b0;
      cmd_rejected <= 1'b0;
      tune_done <= 1'b0;
      tuned_gain <= `GAIN_RST;
      tuned_sp <= `ZERO_MV;
    end else begin
      controller_output <= {heat_v, cool_v};
      output_total <= pv;
      running <= run_ff;
      manual_mode <= manual_now;
      auto_tuning <= at_busy;
      cmd_rejected <= bad;
      tune_done <= at_done;
      tuned_gain <= at_gain;
      tuned_sp <= at_sp;
    end
  end
  a_manual_wins: assert property (@(posedge sys_clk) disable iff (!arst_n)
    manual_now |=> output_total == $past(man_ff))
    else $error("manual output not selected");
  a_stop_output: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!manual_now && !run_ff) |=> output_total == $past(stop_ff))
    else $error("stop output not selected");
  a_err_output: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!manual_now && run_ff && !at_busy && (pv_error || rsp_error)) |=>
    output_total == $past(err_ff))
    else $error("error output not selected");
  a_limit_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!manual_now && run_ff && !at_busy && !pv_error && !rsp_error && lim_on) |=>
    (output_total <= $past(lim_hi_eff)) && (output_total >= $past(lim_in_lo)))
    else $error("limited output out of range");
  a_refuse_tune: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (at_req && !run_ff && !at_busy) |=> !at_busy && cmd_rejected)
    else $error("tuning started while stopped");
  a_block_param: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (at_busy && host_cmd.cmd == cmd_param) |=> cmd_rejected && $stable(hi_ff))
    else $error("parameter taken during tuning");
  a_cool_side: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (heat_cool && pv[15]) |=> controller_output.heat == `ZERO_MV)
    else $error("negative output reached heating side");
  a_no_reduced_hc: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (heat_cool && host_cmd.cmd == cmd_at_reduced && !at_busy) |=> !at_busy)
    else $error("reduced tuning in heat cool mode");
endmodule

// ===== tb/host_model.sv
// host and process model: one-cycle commands, plant that follows the output
// assumes the caller drives other inputs one time unit after the rising edge
`timescale 1ns/10ps
module host_model
  import mv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic signed [15:0] output_total,
  input wire logic signed [15:0] setpoint_value,
  output mv_pkg::host_cmd_s host_cmd,
  output logic signed [15:0] measured_value
);
  initial host_cmd = '{cmd_none, par_manual, 16'sh0000};
  // plant heats while output positive, bounded around setpoint
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      measured_value <= 16'sh012c;
    end else if (output_total > 0 && measured_value < setpoint_value + 16'sh00c8) begin
      measured_value <= measured_value + 16'sh0005;
    end else if (output_total <= 0 && measured_value > setpoint_value - 16'sh00c8) begin
      measured_value <= measured_value - 16'sh0005;
    end
  end
  // one command, held for exactly one taking edge
  task automatic issue(input cmd_e c, input par_e p, input logic signed [15:0] v);
    @(posedge sys_clk);
    #1 host_cmd = '{c, p, v};
    @(posedge sys_clk);
    #1 host_cmd = '{cmd_none, par_manual, 16'sh0000};
  endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for output selection, limiter and autotune
// assumes mv_pkg and the design files are compiled first
`timescale 1ns/10ps
module tb;
  import mv_pkg::*;
  logic sys_clk, arst_n, event_mode_en, event_in, heat_cool, two_dof_pid;
  logic self_tuning_en, on_off_ctl, pv_error, rsp_error, running, manual_mode;
  logic auto_tuning, cmd_rejected, tune_done;
  logic signed [15:0] pid_output, setpoint_value, measured_value, output_total;
  logic signed [15:0] tuned_gain, tuned_sp, hi, lo;
  host_cmd_s host_cmd;
  out_pair_s controller_output;
  int error_cnt = 0, comparisons = 0, rej_cnt = 0, done_cnt = 0, seed, i, seen;
  mv_select dut (.sys_clk(sys_clk), .arst_n(arst_n), .host_cmd(host_cmd),
    .event_mode_en(event_mode_en), .event_in(event_in), .heat_cool(heat_cool),
    .two_dof_pid(two_dof_pid), .self_tuning_en(self_tuning_en), .on_off_ctl(on_off_ctl),
    .pv_error(pv_error), .rsp_error(rsp_error), .pid_output(pid_output),
    .measured_value(measured_value), .setpoint_value(setpoint_value),
    .controller_output(controller_output), .output_total(output_total), .running(running),
    .manual_mode(manual_mode), .auto_tuning(auto_tuning), .cmd_rejected(cmd_rejected),
    .tune_done(tune_done), .tuned_gain(tuned_gain), .tuned_sp(tuned_sp));
  host_model far_end (.sys_clk(sys_clk), .arst_n(arst_n), .output_total(output_total),
    .setpoint_value(setpoint_value), .host_cmd(host_cmd), .measured_value(measured_value));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (cmd_rejected === 1'b1) rej_cnt++;
    if (tune_done === 1'b1) done_cnt++;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk_val(input logic signed [15:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  task automatic chk_pair(input logic signed [15:0] t);
    chk_val(controller_output.heat, t > 0 ? t : 16'sh0000, "heat side");
    chk_val(controller_output.cool, t < 0 ? -t : 16'sh0000, "cool side");
  endtask
  task automatic put(input par_e p, input logic signed [15:0] v);
    far_end.issue(cmd_param, p, v);
  endtask
  task automatic cmd(input cmd_e c);
    far_end.issue(c, par_manual, 16'sh0000);
    step(2);
  endtask
  task automatic try_tune(input cmd_e c, input logic refuse);
    int r;
    r = rej_cnt;
    cmd(c);
    chk_bit(rej_cnt > r, refuse, "tune start refusal");
    chk_bit(auto_tuning, !refuse, "tuning state");
  endtask
  task summarize;
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic signed [15:0] rnd(input int lo_v, input int n);
    rnd = 16'(lo_v + int'({$random(seed)} % n));
  endfunction
  // limiter: larger limit acts as upper, bypass when not 2-dof or self-tuning
  function automatic logic signed [15:0] lim(input logic signed [15:0] v, h, l, input logic en);
    logic signed [15:0] u, d;
    u = h > l ? h : l;
    d = h > l ? l : h;
    if (!en) return v;
    return v > u ? u : (v < d ? d : v);
  endfunction
  initial begin
    seed = 32'h54ab;
    {arst_n, event_mode_en, event_in, heat_cool, self_tuning_en} = 5'h00;
    {on_off_ctl, pv_error, rsp_error, two_dof_pid} = 4'h1;
    pid_output = 16'sh0000;
    setpoint_value = 16'sh0190;
    step(5);
    arst_n = 1'b1;
    step(1);
    chk_val(output_total, 16'sh0000, "reset output");
    chk_pair(16'sh0000);
    chk_val(tuned_gain, 16'sh0008, "reset gain");
    try_tune(cmd_at_full, 1'b1);
    put(par_stop, 16'sh07d0);
    step(2);
    chk_val(output_total, 16'sh041a, "stop output clamp");
    put(par_stop, -16'sh0064);
    step(2);
    chk_val(output_total, -16'sh0032, "stop output low clamp");
    heat_cool = 1'b1;
    put(par_stop, -16'sh012c);
    step(2);
    chk_pair(-16'sh012c);
    put(par_stop, 16'sh0000);
    heat_cool = 1'b0;
    put(par_err, 16'sh00fa);
    put(par_manual, 16'sh0258);
    pv_error = 1'b1;
    step(2);
    chk_val(output_total, 16'sh0000, "stop over error");
    cmd(cmd_run);
    chk_bit(running, 1'b1, "running");
    chk_val(output_total, 16'sh00fa, "measured error output");
    pv_error = 1'b0;
    rsp_error = 1'b1;
    step(2);
    chk_val(output_total, 16'sh00fa, "remote error output");
    cmd(cmd_manual);
    chk_val(output_total, 16'sh0258, "manual over error");
    cmd(cmd_auto);
    rsp_error = 1'b0;
    event_mode_en = 1'b1;
    event_in = 1'b1;
    step(2);
    chk_bit(manual_mode, 1'b1, "event on manual");
    chk_val(output_total, 16'sh0258, "event manual output");
    event_in = 1'b0;
    step(2);
    chk_bit(manual_mode, 1'b0, "event off auto");
    event_mode_en = 1'b0;
    for (i = 0; i < 24; i++) begin
      hi = i == 0 ? 16'sh012c : rnd(-50, 1101);
      lo = i == 0 ? 16'sh0258 : rnd(-50, 1101);
      put(par_lim_hi, hi);
      put(par_lim_lo, lo);
      two_dof_pid = i % 4 != 2;
      self_tuning_en = i % 4 == 3;
      pid_output = rnd(-1050, 2101);
      step(2);
      chk_val(output_total, lim(pid_output, hi, lo, two_dof_pid && !self_tuning_en), "limit");
    end
    {two_dof_pid, self_tuning_en} = 2'b10;
    put(par_lim_hi, 16'sh041a);
    put(par_lim_lo, -16'sh0032);
    cmd(cmd_manual);
    try_tune(cmd_at_full, 1'b1);
    cmd(cmd_auto);
    on_off_ctl = 1'b1;
    try_tune(cmd_at_full, 1'b1);
    on_off_ctl = 1'b0;
    heat_cool = 1'b1;
    try_tune(cmd_at_reduced, 1'b1);
    heat_cool = 1'b0;
    put(par_gain, 16'sh0014);
    pid_output = -16'sh0064;
    step(90);
    try_tune(cmd_at_full, 1'b0);
    chk_val(output_total, 16'sh03e8, "full swing high");
    i = rej_cnt;
    put(par_manual, 16'sh0064);
    cmd(cmd_latch_cancel);
    chk_val(16'(rej_cnt - i), 16'sh0001, "param refused, latch taken");
    for (i = 0; i < 3000 && done_cnt == 0; i++) step(1);
    if (done_cnt == 0) begin
      error_cnt++;
      $display("CHECK FAILED %0t tuning did not finish", $time);
    end
    step(1);
    chk_val(tuned_sp, 16'sh0190, "tuned setpoint");
    chk_val(tuned_gain, 16'sh0014, "tuned gain");
    chk_bit(auto_tuning, 1'b0, "tuning ended");
    try_tune(cmd_at_full, 1'b0);
    cmd(cmd_stop);
    chk_bit(auto_tuning, 1'b0, "stop cancels");
    cmd(cmd_run);
    chk_bit(auto_tuning, 1'b0, "no restart");
    put(par_hys, 16'sh0064);
    put(par_amp, 16'sh0064);
    try_tune(cmd_at_reduced, 1'b0);
    seen = 0;
    for (i = 0; i < 60; i++) begin
      step(1);
      if (output_total === 16'sh0064) seen++;
      else chk_val(output_total, 16'sh0000, "reduced swing");
    end
    chk_bit(seen > 0, 1'b1, "reduced swing seen");
    cmd(cmd_at_cancel);
    chk_bit(auto_tuning, 1'b0, "tuning cancelled");
    summarize();
  end
endmodule
